// ===== wwr_pkg.sv
`default_nettype none
package wwr_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_CLK_WIN = 12'h000;
   localparam logic [11:0] ADDR_PS_LOW = 12'h004;
   localparam logic [11:0] ADDR_PS_HIGH = 12'h008;
   localparam logic [11:0] ADDR_TIMER = 12'h00C;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
   localparam logic [11:0] ADDR_CLEAR = 12'h018;
   // field positions
   localparam int CS_LSB = 4;
   localparam int WIN_LSB = 0;
   localparam int TMR_LSB = 3;
   localparam int ARMED_BIT = 2;
   localparam int PS_HI_LSB = 16;
   localparam int CLEAR_BIT = 0;
   // codes
   localparam logic [2:0] CFG_UNLOCKED = 3'h7;
   localparam logic [2:0] CS_LOW_FREQ_OSC = 3'h0;
   localparam logic [2:0] CS_MID_FREQ_OSC = 3'h1;
   localparam logic [2:0] WIN_FULL_OPEN = 3'h7;
   // interrupt status bit positions and status width
   localparam int IRQ_VIOL = 0;
   localparam int IRQ_TIMEOUT = 1;
   localparam int IRQ_W = 2;
   // configuration word fields
   typedef struct packed {
      logic [2:0] clock_select_default;
      logic [2:0] open_period_default;
   } wwr_cfg_t;
endpackage
`default_nettype wire

// ===== wwr_regs.sv
// Notes on behaviour
// - Clock-select code 000 picks the low-frequency oscillator, 001 the mid one, others reserved.
// - Window code 000 closes 7/8 of a period, each step up closes 1/8 less, 111 is fully open.
// - With a clock-select default of 111 the clock-select field resets to 000.
// - The window field resets to the window default held in the configuration word.
// - Each field is writable only when its configuration default is 111.
// - The 18-bit prescale count is spread over low, high and timer registers.
// - Prescale and timer fields are read-only and read zero after any reset.
// - Timer register bits 6:3 show the 4-bit timer value.
// - Timer register bit 2 shows whether the watchdog is armed.
// - Unimplemented bits read as zero.
//
// The address map and the APB register port were left to the implementer.
`default_nettype none
module wwr_regs
   import wwr_pkg::*;
#(
   parameter int PS_W = 18,
   parameter int TMR_W = 4
) (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire wwr_cfg_t cfg, // configuration word fields
   input wire logic wdt_enable, // watchdog armed request
   input wire logic wdt_tick, // one pulse per watchdog clock
   output logic [2:0] wdt_clock_select, // selected watchdog clock
   output logic window_violation_flag, // sticky violation flag
   output logic reset_request, // device reset pulse
   output logic irq // level interrupt
);
   logic [2:0] win_sel;
   logic [PS_W-1:0] prescale_count;
   logic [TMR_W-1:0] timer_count_field;
   logic armed;
   logic [IRQ_W-1:0] irq_stat, irq_mask;
   logic [31:0] next_prdata;
   logic next_slverr;
   logic cfg_seen;
   // apb decode
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire hit_cw = paddr == ADDR_CLK_WIN;
   wire hit_pl = paddr == ADDR_PS_LOW;
   wire hit_ph = paddr == ADDR_PS_HIGH;
   wire hit_tm = paddr == ADDR_TIMER;
   wire hit_is = paddr == ADDR_IRQ_STAT;
   wire hit_im = paddr == ADDR_IRQ_MASK;
   wire hit_cl = paddr == ADDR_CLEAR;
   wire mapped = hit_cw | hit_pl | hit_ph | hit_tm | hit_is | hit_im | hit_cl;
   wire cs_unlocked = cfg.clock_select_default == CFG_UNLOCKED;
   wire win_unlocked = cfg.open_period_default == CFG_UNLOCKED;
   wire wr_cw = wr && hit_cw;
   // closed part: first (7 - code) eighths of the period, code 111 never closed
   wire [2:0] ps_eighth = prescale_count[PS_W-1 -: 3];
   wire window_closed = (win_sel != WIN_FULL_OPEN) && (ps_eighth < (WIN_FULL_OPEN - win_sel));
   wire clear_req = wr && hit_cl && pwdata[CLEAR_BIT];
   wire violation = clear_req && armed && window_closed;
   wire ps_wrap = wdt_tick && armed && (&prescale_count);
   wire timeout = ps_wrap && (&timer_count_field);
   wire [IRQ_W-1:0] events = {timeout, violation};
   // reset defaults: config held steady, caught after reset release
   wire [2:0] cs_default = cs_unlocked ? CS_LOW_FREQ_OSC : cfg.clock_select_default;
   // read mux
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      if (hit_cw) begin
         next_prdata[CS_LSB +: 3] = wdt_clock_select;
         next_prdata[WIN_LSB +: 3] = win_sel;
      end else if (hit_pl) begin
         next_prdata[7:0] = prescale_count[7:0];
      end else if (hit_ph) begin
         next_prdata[7:0] = prescale_count[15:8];
      end else if (hit_tm) begin
         next_prdata[TMR_LSB +: TMR_W] = timer_count_field;
         next_prdata[ARMED_BIT] = armed;
         next_prdata[1:0] = prescale_count[PS_W-1 -: 2];
      end else if (hit_is) begin
         next_prdata[IRQ_W-1:0] = irq_stat;
      end else if (hit_im) begin
         next_prdata[IRQ_W-1:0] = irq_mask;
      end else if (!mapped) begin
         next_slverr = 1'b1;
      end
   end
   // bus outputs: zero-wait answer, registered data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && next_slverr;
         prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
      end
   end
   // control fields, loaded from configuration once after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_seen <= 1'b0;
         wdt_clock_select <= CS_LOW_FREQ_OSC;
         win_sel <= WIN_FULL_OPEN;
      end else if (!cfg_seen) begin
         cfg_seen <= 1'b1;
         wdt_clock_select <= cs_default;
         win_sel <= cfg.open_period_default;
      end else if (wr_cw && pready) begin
         if (cs_unlocked) wdt_clock_select <= pwdata[CS_LSB +: 3];
         if (win_unlocked) win_sel <= pwdata[WIN_LSB +: 3];
      end
   end
   // prescale and timer counters, software cannot write them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_count <= '0;
         timer_count_field <= '0;
         armed <= 1'b0;
      end else begin
         armed <= wdt_enable;
         if (!wdt_enable || (clear_req && pready) || timeout) begin
            prescale_count <= '0;
            timer_count_field <= '0;
         end else if (wdt_tick) begin
            prescale_count <= prescale_count + 1'b1;
            if (&prescale_count) timer_count_field <= timer_count_field + 1'b1;
         end
      end
   end
   // violation flag and reset request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_violation_flag <= 1'b0;
         reset_request <= 1'b0;
      end else begin
         if (violation && pready) window_violation_flag <= 1'b1;
         reset_request <= (violation && pready) || (timeout && !(clear_req && pready));
      end
   end
   // sticky interrupt status, cleared by read, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat <= ((rd && hit_is && pready) ? '0 : irq_stat) | (events & {1'b1, pready});
         if (wr && hit_im && pready) irq_mask <= pwdata[IRQ_W-1:0];
         irq <= |(irq_stat & irq_mask);
      end
   end
endmodule
`default_nettype wire

// ===== wwr_regs_bench.sv
`default_nettype none
module wwr_regs_bench
   import wwr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdt_enable, wdt_tick, irq, slv;
   logic window_violation_flag, reset_request;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] wdt_clock_select;
   wwr_cfg_t cfg;
   int bad_count = 0, checked = 0, cyc = 0;
   wwr_regs dut (.*);
   // clock and hang ceiling
   initial begin
      pclk = 1'h0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic close_out();
      if (bad_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer, held until pready
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   task automatic do_reset(input wwr_cfg_t c);
      cfg <= c;
      presetn <= 1'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      repeat (2) @(posedge pclk);
   endtask
   // main sequence
   initial begin
      {psel, penable, pwrite, wdt_enable, wdt_tick, presetn} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cfg = 6'h3F;
      do_reset(6'h3F);
      rchk("ctrl", ADDR_CLK_WIN, 32'h7);
      rchk("ps_low", ADDR_PS_LOW, 32'h0);
      rchk("timer", ADDR_TIMER, 32'h0);
      wdt_enable <= 1'h1;
      repeat (2) @(posedge pclk);
      xfer(1'h1, ADDR_CLEAR, 32'h1);
      chk("open_flag", 32'(window_violation_flag), 32'h0);
      xfer(1'h1, ADDR_CLK_WIN, 32'hFF98);
      rchk("ctrl", ADDR_CLK_WIN, 32'h10);
      chk("clksel", 32'(wdt_clock_select), 32'h1);
      wdt_enable <= 1'h1;
      repeat (3) begin
         @(posedge pclk) wdt_tick <= 1'h1;
         @(posedge pclk) wdt_tick <= 1'h0;
      end
      rchk("ps_low", ADDR_PS_LOW, 32'h3);
      rchk("timer", ADDR_TIMER, 32'h4);
      xfer(1'h1, ADDR_IRQ_MASK, 32'h1);
      xfer(1'h1, ADDR_CLEAR, 32'h1);
      @(posedge pclk);
      chk("rstreq", 32'(reset_request), 32'h1);
      repeat (3) @(posedge pclk);
      chk("flag", 32'(window_violation_flag), 32'h1);
      chk("irq", 32'(irq), 32'h1);
      rchk("status", ADDR_IRQ_STAT, 32'h1);
      rchk("status", ADDR_IRQ_STAT, 32'h0);
      chk("irq", 32'(irq), 32'h0);
      rchk("unmapped", 12'h01C, 32'h0);
      chk("slverr", 32'(slv), 32'h1);
      do_reset(6'h0D);
      xfer(1'h1, ADDR_CLK_WIN, 32'h0);
      rchk("ctrl", ADDR_CLK_WIN, 32'h15);
      chk("flag", 32'(window_violation_flag), 32'h0);
      close_out();
   end
endmodule
`default_nettype wire

// ===== wwr_regs_checker.sv
`default_nettype none
module wwr_regs_checker
   import wwr_pkg::*;
(
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // apb ready
   input wire wwr_cfg_t cfg, // configuration
   input wire logic [2:0] wdt_clock_select, // clock select
   input wire logic window_violation_flag, // sticky violation
   input wire logic reset_request, // reset pulse
   input wire logic irq // interrupt
);
   // completed reads per register
   wire logic rcw = pready && !pwrite && paddr == ADDR_CLK_WIN;
   wire logic rtm = pready && !pwrite && paddr == ADDR_TIMER;
   wire logic rps = pready && !pwrite && (paddr == ADDR_PS_LOW || paddr == ADDR_PS_HIGH);
   wire logic [2:0] dcs = cfg.clock_select_default;
   wire logic lk = dcs != CFG_UNLOCKED;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_cs_reset: assert property ($rose(presetn) && !lk |=> wdt_clock_select == 3'h0)
      else $error("clock select not cleared");
   chk_cs_locked: assert property ($past(presetn) && lk |-> wdt_clock_select == dcs)
      else $error("locked clock select moved");
   chk_cs_read: assert property (rcw |-> prdata[6:4] == wdt_clock_select)
      else $error("clock select read mismatch");
   chk_gap_bit: assert property (rcw |-> !prdata[3])
      else $error("control bit 3 set");
   chk_top_bits: assert property (rcw || rtm |-> prdata[31:7] == 25'h0)
      else $error("unused high bits set");
   chk_ps_byte: assert property (rps |-> prdata[31:8] == 24'h0)
      else $error("prescale byte too wide");
   chk_flag_sticky: assert property (window_violation_flag |=> window_violation_flag)
      else $error("violation flag dropped");
   chk_flag_reset: assert property ($rose(window_violation_flag) |-> ##[0:2] reset_request)
      else $error("no reset after violation");
   cov_ctrl_read: cover property (rcw);
   cov_violation: cover property ($rose(window_violation_flag));
   cov_irq: cover property (irq);
endmodule
bind wwr_regs wwr_regs_checker chk_i (.*);
`default_nettype wire
